// >>> shared/bsp_defines.vh
// Constants for the bit-serial port engine
`ifndef BSP_DEFINES_VH
`define BSP_DEFINES_VH
`define BSP_BASE_LSB 1
`define BSP_BASE_MSB 11
`define BSP_ADDR_W 11
`define BSP_CNT_W 5
`define BSP_MAX_BITS 5'h10
`define BSP_PHASE_DIV 2'h3
`define BSP_ST_IDLE 2'h0
`define BSP_ST_ADDR 2'h1
`define BSP_ST_XFER 2'h2
`define BSP_ST_DONE 2'h3
`endif

// >>> rtl/bsp_port.v
// Bit-serial I/O port engine: address phase, strobe and serial shift
`timescale 1ns/1ps
`include "bsp_defines.vh"

module bsp_port
#(
   parameter [1:0] PHASE_DIV = `BSP_PHASE_DIV // Clocks per phase cycle
)
(
   input wire clk_sys_i, // System clock
   input wire arst_n_i, // Async reset, active low
   input wire start_i, // Pulse: begin a transfer
   input wire dir_out_i, // 1 output, 0 input
   input wire [15:0] base_reg_i, // Port base register
   input wire [4:0] nbits_i, // Bit count 1..16, 0 means 16
   input wire [15:0] wdata_i, // Output bits, lsb first
   input wire serial_bit_in_i, // Serial input line
   output wire busy_o, // Transfer in progress
   output reg done_o, // Pulse: transfer complete
   output reg [15:0] rdata_o, // Input bits, right justified
   output reg port_cycle_o, // Address bus holds a port address
   output reg [13:0] addr_o, // Address lines 0..13 (bit 13 = serial out)
   output reg bit_strobe_o // Bit strobe
);

   localparam [1:0] ST_IDLE = `BSP_ST_IDLE;
   localparam [1:0] ST_ADDR = `BSP_ST_ADDR;
   localparam [1:0] ST_XFER = `BSP_ST_XFER;
   localparam [1:0] ST_DONE = `BSP_ST_DONE;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [1:0] ph_ff;
   reg [`BSP_ADDR_W-1:0] bitaddr_ff;
   reg [`BSP_CNT_W-1:0] left_ff;
   reg [`BSP_CNT_W-1:0] total_ff;
   reg [15:0] shw_ff;
   reg [15:0] shr_ff;
   reg dir_ff;
   wire ph3;
   wire strobe_ph;
   wire take_start;
   wire addr_end;
   wire xfer_end;
   wire last_bit;

   // Zero stands for a full word of 16 bits
   function [`BSP_CNT_W-1:0] bsp_count;
      input [`BSP_CNT_W-1:0] n;
   begin
      bsp_count = (n == {`BSP_CNT_W{1'b0}}) ? `BSP_MAX_BITS : n;
   end
   endfunction

   function [`BSP_ADDR_W-1:0] bsp_step;
      input [`BSP_ADDR_W-1:0] a;
   begin
      bsp_step = a + {{(`BSP_ADDR_W-1){1'b0}}, 1'b1};
   end
   endfunction

   // Register bits count from the msb, so bits 4..14 sit at [11:1]; the lsb is dropped
   function [`BSP_ADDR_W-1:0] bsp_base;
      input [15:0] r;
   begin
      bsp_base = r[`BSP_BASE_MSB:`BSP_BASE_LSB];
   end
   endfunction

   // Phase 3 enable: one cycle per divider period stands in for the processor's phase clock
   assign ph3 = (ph_ff == PHASE_DIV - 2'h1);
   assign strobe_ph = (ph_ff == PHASE_DIV - 2'h2);
   assign busy_o = (state_ff != ST_IDLE);
   assign take_start = (state_ff == ST_IDLE) && start_i;
   assign addr_end = (state_ff == ST_ADDR) && ph3;
   assign xfer_end = (state_ff == ST_XFER) && ph3;
   assign last_bit = (left_ff == {{(`BSP_CNT_W-1){1'b0}}, 1'b1});

   always @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         ph_ff <= 2'h0;
      else if (ph3)
         ph_ff <= 2'h0;
      else
         ph_ff <= ph_ff + 2'h1;
   end

   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (start_i)
               nxt_state = ST_ADDR;
         end
         ST_ADDR:
         begin
            // Address stands through one phase 3 before any bit moves
            if (ph3)
               nxt_state = ST_XFER;
         end
         ST_XFER:
         begin
            if (ph3 && last_bit)
               nxt_state = ST_DONE;
            else if (ph3)
               nxt_state = ST_ADDR;
         end
         ST_DONE:
         begin
            nxt_state = ST_IDLE;
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   always @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         bitaddr_ff <= {`BSP_ADDR_W{1'b0}};
      else if (take_start)
         bitaddr_ff <= bsp_base(base_reg_i);
      else if (xfer_end)
         bitaddr_ff <= bsp_step(bitaddr_ff);
   end

   always @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         left_ff <= {`BSP_CNT_W{1'b0}};
         total_ff <= {`BSP_CNT_W{1'b0}};
      end
      else if (take_start)
      begin
         left_ff <= bsp_count(nbits_i);
         total_ff <= bsp_count(nbits_i);
      end
      else if (xfer_end)
         left_ff <= left_ff - {{(`BSP_CNT_W-1){1'b0}}, 1'b1};
   end

   always @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         dir_ff <= 1'b0;
         shw_ff <= 16'h0000;
      end
      else if (take_start)
      begin
         dir_ff <= dir_out_i;
         shw_ff <= wdata_i;
      end
      else if (xfer_end)
         shw_ff <= {1'b0, shw_ff[15:1]};
   end

   // New bits enter at the msb, so the first one lands lowest after the justify shift
   always @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         shr_ff <= 16'h0000;
      else if (take_start)
         shr_ff <= 16'h0000;
      else if (addr_end && !dir_ff)
         shr_ff <= {serial_bit_in_i, shr_ff[15:1]};
   end

   always @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         done_o <= 1'b0;
         rdata_o <= 16'h0000;
      end
      else
      begin
         done_o <= (state_ff == ST_DONE);
         if (state_ff == ST_DONE)
         begin
            // Right justify: unused upper bits read zero
            rdata_o <= shr_ff >> (`BSP_MAX_BITS - total_ff);
         end
      end
   end

   // Bus drive: address on 2..12, 0 and 1 held low, line 13 carries data only
   always @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         addr_o <= 14'h0000;
         port_cycle_o <= 1'b0;
         bit_strobe_o <= 1'b0;
      end
      else
      begin
         port_cycle_o <= (nxt_state == ST_ADDR) || (nxt_state == ST_XFER);
         addr_o[1:0] <= 2'h0;
         if (take_start)
            addr_o[12:2] <= bsp_base(base_reg_i);
         else if (xfer_end)
            addr_o[12:2] <= bsp_step(bitaddr_ff);
         else
            addr_o[12:2] <= bitaddr_ff;
         // Idles low outside the data slot so a stale bit never rides with the next address
         addr_o[13] <= (nxt_state == ST_XFER) && dir_ff && shw_ff[0];
         // Registered one cycle early so the strobe lands on the phase 3 of the data slot
         bit_strobe_o <= dir_ff && (state_ff == ST_XFER) && strobe_ph;
      end
   end

endmodule // bsp_port

// >>> bench/bsp_port_asserts.sv
// Assertions on the port engine pins
`timescale 1ns/1ps
module bsp_chk (
   input wire clk_sys_i, // clock
   input wire arst_n_i, // reset
   input wire start_i, // start
   input wire [15:0] base_reg_i, // base
   input wire busy_o, // busy
   input wire done_o, // done
   input wire port_cycle_o, // port cycle
   input wire [13:0] addr_o, // lines
   input wire bit_strobe_o // strobe
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_tk; start_i && !busy_o; endsequence
   property p_lo; addr_o[1:0] == 2'h0; endproperty
   a_lo: assert property (p_lo) else $error("low lines set");
   property p_tk; s_tk |=> port_cycle_o && addr_o[12:2] == $past(base_reg_i[11:1]); endproperty
   a_tk: assert property (p_tk) else $error("bad base");
   property p_sb; bit_strobe_o |-> busy_o && port_cycle_o && $stable(addr_o[12:2]); endproperty
   a_sb: assert property (p_sb) else $error("strobe off slot");
   property p_sg; bit_strobe_o |=> !bit_strobe_o [*2]; endproperty
   a_sg: assert property (p_sg) else $error("strobes too close");
   property p_in; port_cycle_o && $past(port_cycle_o) && !$past(start_i) && $changed(addr_o[12:2])
      |-> addr_o[12:2] == $past(addr_o[12:2]) + 11'h001; endproperty
   a_in: assert property (p_in) else $error("address step");
   property p_bz; s_tk |=> busy_o [*3]; endproperty
   a_bz: assert property (p_bz) else $error("busy dropped");
   property p_dn; done_o |=> !done_o; endproperty
   a_dn: assert property (p_dn) else $error("done too long");
   property p_fi; s_tk |-> ##[1:200] done_o; endproperty
   a_fi: assert property (p_fi) else $error("no done");
endmodule // bsp_chk

// >>> bench/bsp_periph.sv
// Far-side model: decode, input source, output capture
`timescale 1ns/1ps
module bsp_periph (
   input wire clk_sys_i, // clock
   input wire port_cycle_i, // port cycle
   input wire [13:0] addr_i, // lines
   input wire bit_strobe_i, // strobe
   output wire serial_bit_in_o // serial in
);
   reg [2047:0] seen_ff = 2048'h0;
   reg tog_ff = 1'b0;
   // One 32-bit window per a[12:11]
   wire sel = port_cycle_i && addr_i[10:7] == 4'h0;
   // Unselected line toggles so a stale level cannot pass
   assign serial_bit_in_o = sel ? addr_i[2] ^ addr_i[5] ^ addr_i[12] : tog_ff;
   always @(posedge clk_sys_i) tog_ff <= !tog_ff;
   always @(posedge clk_sys_i) if (bit_strobe_i && sel)
      seen_ff[addr_i[12:2]] <= addr_i[13];
endmodule // bsp_periph

// >>> bench/tb_bit_serial_io_port_decode.sv
// Random and corner transfers on the port engine
`timescale 1ns/1ps
module tb_bit_serial_io_port_decode;
   reg clk_sys_i = 1'b0, arst_n_i = 1'b0, start_i = 1'b0, dir_out_i = 1'b0;
   reg [15:0] base_reg_i = 16'h0000, wdata_i = 16'h0000, e;
   reg [4:0] nbits_i = 5'h00;
   reg [10:0] b;
   wire serial_bit_in_i, busy_o, done_o, port_cycle_o, bit_strobe_o;
   wire [15:0] rdata_o;
   wire [13:0] addr_o;
   integer miscompares = 0, checks_done = 0, seed = 69, cyc = 0, i, j, w, r, strobes = 0, s0;
   always #5 clk_sys_i = !clk_sys_i;
   always @(negedge clk_sys_i) strobes = strobes + bit_strobe_o;
   bsp_port bsp_port_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .start_i(start_i), .dir_out_i(dir_out_i),
      .base_reg_i(base_reg_i), .nbits_i(nbits_i), .wdata_i(wdata_i), .serial_bit_in_i(serial_bit_in_i),
      .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .port_cycle_o(port_cycle_o), .addr_o(addr_o),
      .bit_strobe_o(bit_strobe_o));
   bsp_periph bsp_periph_i (.clk_sys_i, .port_cycle_i(port_cycle_o), .addr_i(addr_o),
      .bit_strobe_i(bit_strobe_o), .serial_bit_in_o(serial_bit_in_i));
   task give_verdict;
      miscompares += (cyc >= 9000);
      if (miscompares == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      checks_done++;
      miscompares += (got !== exp);
      if (got !== exp)
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
   endtask
   task xfer;
      r = $random(seed);
      e = $random(seed);
      s0 = strobes;
      b = {j[1:0], 5'h00, r[8:5]};
      @(posedge clk_sys_i);
      start_i <= 1'b1;
      dir_out_i <= r[0];
      nbits_i <= (j < 2) ? j[4:0] : {1'b0, r[4:1]};
      wdata_i <= e;
      base_reg_i <= {r[13:10], b, r[9]};
      @(posedge clk_sys_i);
      start_i <= 1'b0;
      for (w = 0; w < 300 && done_o !== 1'b1; w++)
         @(negedge clk_sys_i);
      w = (nbits_i == 5'h00) ? 16 : nbits_i;
      chk(done_o, 1'b1);
      chk(16'(strobes - s0), 16'(r[0] ? w : 0));
      for (i = 0; i < 16; i++)
         chk(r[0] ? (i < w ? bsp_periph_i.seen_ff[b + i] : 1'b0) : rdata_o[i],
            i < w && (r[0] ? e[i] : ^(11'(b + i) & 11'h409)));
   endtask
   initial
   begin
      repeat (5) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      for (j = 0; j < 32; j++)
         xfer;
      // Reset in mid-transfer: all outputs fall at once and the engine starts over
      @(posedge clk_sys_i);
      start_i <= 1'b1;
      dir_out_i <= 1'b1;
      @(posedge clk_sys_i);
      start_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      arst_n_i <= 1'b0;
      @(negedge clk_sys_i);
      chk({busy_o, done_o, port_cycle_o, bit_strobe_o}, 16'h0000);
      chk({2'h0, addr_o}, 16'h0000);
      chk(rdata_o, 16'h0000);
      @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      xfer;
      give_verdict;
   end
   always @(posedge clk_sys_i) if (++cyc == 9000)
      give_verdict;
endmodule // tb_bit_serial_io_port_decode
bind bsp_port bsp_chk bsp_chk_i (.clk_sys_i, .arst_n_i, .start_i, .base_reg_i, .busy_o, .done_o,
   .port_cycle_o, .addr_o, .bit_strobe_o);
